// [design/eeprom_config_image_pkg.sv]
// Constants, types and default image for the configuration image unpacker.
// Assumes a front end that streams memory bytes MSB first from address 0.
package eeprom_config_image_pkg;

   localparam int IMAGE_BYTES       = 37;
   localparam int IMAGE_START       = 3;
   localparam int MEMORY_BYTES      = 1024;
   localparam int MAP_ENTRY_SMALL   = 2;
   localparam int MAP_ENTRY_LARGE   = 3;
   localparam int HEADER_FLAGS_ADDR = 0;
   localparam int HEADER_BURST_ADDR = 2;
   localparam int REG_COUNT         = 92;

   // Register indexes inside the control register file
   localparam int REG_POWER_DOWN    = 8'h01;
   localparam int REG_OVERRIDES     = 8'h02;
   localparam int REG_DETECT_A      = 8'h04;
   localparam int REG_SLAVE_CTRL    = 8'h06;
   localparam int REG_PIN_OVERRIDES = 8'h08;
   localparam int REG_DETECT_B      = 8'h0B;
   localparam int REG_CH0_EQ        = 8'h0F;
   localparam int REG_CH0_SWING     = 8'h10;
   localparam int REG_DETECT_OPTS   = 8'h28;
   localparam int REG_TAIL_A        = 8'h47;
   localparam int REG_TAIL_B        = 8'h48;
   localparam int REG_TAIL_C        = 8'h4C;
   localparam int REG_TAIL_D        = 8'h59;
   localparam int REG_COPY_A        = 8'h5A;
   localparam int REG_COPY_B        = 8'h5B;
   localparam int CHAN_LOW_BASE     = 8'h0E;
   localparam int CHAN_HIGH_BASE    = 8'h2B;
   localparam int CHAN_STRIDE       = 7;

   // Bit positions of pin overrides
   localparam int POWER_DOWN_OVR_BIT = 0;
   localparam int THRESHOLD_OVR_BIT  = 6;
   localparam int RXDET_OVR_BIT      = 3;

   // Positions in the image bit stream, bit 0 = byte three bit 7
   localparam int CHAN_FIELD_BITS   = 28;
   localparam int CHAN_LOW_STREAM   = 36;
   localparam int CHAN_HIGH_STREAM  = 155;
   localparam int DETECT_OPT_STREAM = 148;
   localparam int TAIL_STREAM       = 267;
   localparam int COPY_STREAM       = 280;

   typedef logic [IMAGE_BYTES-1:0][7:0] image_t;
   typedef logic [REG_COUNT-1:0][7:0]   regs_t;

   typedef struct packed {
      logic       checksumEnable;
      logic       mapPresent;
      logic       largeMemory;
      logic       reservedBit;
      logic [3:0] deviceCount;
   } header_t;

   typedef enum logic [1:0] {
      IDLE_S = 2'b00,
      LOAD_S = 2'b01,
      DONE_S = 2'b10,
      FAIL_S = 2'b11
   } load_state_t;

   // Image defaults, entry 0 is image byte three
   localparam image_t DEFAULT_IMAGE = {
      8'h54, 8'h54, 8'h00, 8'h00, 8'hA8, 8'hF5, 8'h05, 8'h80, 8'h5A, 8'h5F,
      8'h00, 8'hA8, 8'hF5, 8'h05, 8'h80, 8'h5A, 8'h5F, 8'h80, 8'h09, 8'hD4,
      8'hFA, 8'h02, 8'h40, 8'hAD, 8'h2F, 8'h00, 8'hD4, 8'hFA, 8'h02, 8'h40,
      8'hAD, 8'h2F, 8'h00, 8'h07, 8'h04, 8'h00, 8'h00};

   localparam logic [7:0] CH0_EQ_DEFAULT    = 8'h2F;
   localparam logic [7:0] CH0_SWING_DEFAULT = 8'hAD;

endpackage

// [design/eeprom_config_image_unpacker.sv]
// Loader that unpacks a device configuration image into control registers.
// Assumes an external front end streams memory bytes on linkClock/linkData
// while linkFrame is high, MSB first, starting at memory address zero.
`timescale 1ns/1ps
module eeprom_config_image_unpacker (
   input  wire logic                           clock,
   input  wire logic                           reset,
   input  wire logic                           busModeSelectPin,
   input  wire logic                           readEnableLow,
   input  wire logic [3:0]                     deviceIndex,
   input  wire logic                           linkClock,
   input  wire logic                           linkData,
   input  wire logic                           linkFrame,
   output logic                                loadRequest,
   output logic                                loadDone,
   output logic                                allDone,
   output logic                                loadFailed,
   output logic [7:0]                          burstLength,
   output eeprom_config_image_pkg::regs_t      ctrlRegs,
   output logic                                powerDownPinOverride,
   output logic                                detectThresholdPinOverride,
   output logic                                receiverDetectPinOverride
);
   import eeprom_config_image_pkg::*;

   logic [1:0]  linkClockSync;
   logic [1:0]  linkDataSync;
   logic [1:0]  linkFrameSync;
   logic [1:0]  modeSync;
   logic [1:0]  readEnableSync;
   logic [3:0]  indexSync0;
   logic [3:0]  indexSync1;
   logic        linkClockLast;
   logic        frameLast;
   logic        clockRise;
   logic        frameActive;
   logic        frameEnd;
   logic [2:0]  bitCount_reg;
   logic [7:0]  shift_reg;
   logic        byteStrobe_reg;
   logic [7:0]  byteData_reg;
   logic [10:0] byteAddr_reg;
   load_state_t state_reg;
   header_t     header_reg;
   logic [7:0]  burst_reg;
   logic [7:0]  crcByte_reg;
   logic [7:0]  xorSum_reg;
   logic [9:0]  mapStart_reg;
   image_t      image_reg;
   logic        imageFull_reg;
   logic        checkPass_reg;
   regs_t       ctrlRegs_reg;
   logic [10:0] dataStart;
   logic [10:0] entryBase;
   logic [10:0] dataOffset;
   logic        inImage;
   logic        lastByte;
   logic        commitPulse;
   logic        checksumUsed;

   // Fetch one bit of the image stream
   function automatic logic bitAt(image_t img, int s);
      return img[s / 8][7 - (s % 8)];
   endfunction

   // Scatter every image bit to its register bit; other bits keep base
   function automatic regs_t scatterImage(image_t img, regs_t base);
      regs_t r;
      int    b;
      int    s;
      r = base;
      for (int j = 0; j < 8; j++) begin
         r[REG_POWER_DOWN][7-j] = bitAt(img, j);
      end
      for (int j = 0; j < 4; j++) begin
         r[REG_OVERRIDES][5-j] = bitAt(img, 8 + j);
      end
      r[REG_OVERRIDES][POWER_DOWN_OVR_BIT] = bitAt(img, 12);
      for (int j = 0; j < 8; j++) begin
         r[REG_DETECT_A][7-j] = bitAt(img, 13 + j);
      end
      r[REG_SLAVE_CTRL][4] = bitAt(img, 21);
      for (int j = 0; j < 7; j++) begin
         r[REG_PIN_OVERRIDES][6-j] = bitAt(img, 22 + j);
      end
      for (int j = 0; j < 7; j++) begin
         r[REG_DETECT_B][6-j] = bitAt(img, 29 + j);
      end
      // Eight identical channel groups, two runs of four
      for (int k = 0; k < 8; k++) begin
         b = (k < 4) ? CHAN_LOW_BASE + CHAN_STRIDE * k
                     : CHAN_HIGH_BASE + CHAN_STRIDE * (k - 4);
         s = (k < 4) ? CHAN_LOW_STREAM + CHAN_FIELD_BITS * k
                     : CHAN_HIGH_STREAM + CHAN_FIELD_BITS * (k - 4);
         for (int j = 0; j < 4; j++) begin
            r[b][5-j] = bitAt(img, s + j);
         end
         for (int j = 0; j < 8; j++) begin
            r[b+1][7-j] = bitAt(img, s + 4 + j);
            r[b+2][7-j] = bitAt(img, s + 12 + j);
         end
         for (int j = 0; j < 3; j++) begin
            r[b+3][2-j] = bitAt(img, s + 20 + j);
         end
         r[b+4][7] = bitAt(img, s + 23);
         for (int j = 0; j < 4; j++) begin
            r[b+4][3-j] = bitAt(img, s + 24 + j);
         end
      end
      for (int j = 0; j < 7; j++) begin
         r[REG_DETECT_OPTS][6-j] = bitAt(img, DETECT_OPT_STREAM + j);
      end
      for (int j = 0; j < 4; j++) begin
         r[REG_TAIL_A][3-j] = bitAt(img, TAIL_STREAM + j);
      end
      r[REG_TAIL_B][7] = bitAt(img, TAIL_STREAM + 4);
      r[REG_TAIL_B][6] = bitAt(img, TAIL_STREAM + 5);
      for (int j = 0; j < 5; j++) begin
         r[REG_TAIL_C][7-j] = bitAt(img, TAIL_STREAM + 6 + j);
      end
      r[REG_TAIL_C][0] = bitAt(img, TAIL_STREAM + 11);
      r[REG_TAIL_D][0] = bitAt(img, TAIL_STREAM + 12);
      for (int j = 0; j < 8; j++) begin
         r[REG_COPY_A][7-j] = bitAt(img, COPY_STREAM + j);
         r[REG_COPY_B][7-j] = bitAt(img, COPY_STREAM + 8 + j);
      end
      return r;
   endfunction

   // Pin synchronisers; only the second stage is read by logic
   always_ff @(posedge clock) begin
      if (reset) begin
         linkClockSync  <= 2'h0;
         linkDataSync   <= 2'h0;
         linkFrameSync  <= 2'h0;
         modeSync       <= 2'h0;
         readEnableSync <= 2'h3;
         indexSync0     <= 4'h0;
         indexSync1     <= 4'h0;
         linkClockLast  <= 1'b0;
         frameLast      <= 1'b0;
      end else begin
         linkClockSync  <= {linkClockSync[0], linkClock};
         linkDataSync   <= {linkDataSync[0], linkData};
         linkFrameSync  <= {linkFrameSync[0], linkFrame};
         modeSync       <= {modeSync[0], busModeSelectPin};
         readEnableSync <= {readEnableSync[0], readEnableLow};
         indexSync0     <= deviceIndex;
         indexSync1     <= indexSync0;
         linkClockLast  <= linkClockSync[1];
         frameLast      <= linkFrameSync[1];
      end
   end

   assign clockRise   = linkClockSync[1] & ~linkClockLast;
   assign frameActive = linkFrameSync[1];
   assign frameEnd    = frameLast & ~frameActive;

   // Byte assembly; the link clock is only trusted inside a frame
   always_ff @(posedge clock) begin
      if (reset) begin
         bitCount_reg   <= 3'h0;
         shift_reg      <= 8'h00;
         byteStrobe_reg <= 1'b0;
         byteData_reg   <= 8'h00;
      end else begin
         byteStrobe_reg <= 1'b0;
         if (!frameActive) begin
            bitCount_reg <= 3'h0;
         end else if (clockRise) begin
            shift_reg    <= {shift_reg[6:0], linkDataSync[1]};
            bitCount_reg <= bitCount_reg + 3'h1;
            if (bitCount_reg == 3'h7) begin
               byteStrobe_reg <= 1'b1;
               byteData_reg   <= {shift_reg[6:0], linkDataSync[1]};
            end
         end
      end
   end

   // Memory address of the byte on byteData_reg
   always_ff @(posedge clock) begin
      if (reset) begin
         byteAddr_reg <= 11'h000;
      end else if (!frameActive) begin
         byteAddr_reg <= 11'h000;
      end else if (byteStrobe_reg) begin
         byteAddr_reg <= byteAddr_reg + 11'h001;
      end
   end

   // Where this device's map entry and image sit in memory
   assign entryBase = 11'(IMAGE_START + int'(indexSync1) *
                      (header_reg.largeMemory ? MAP_ENTRY_LARGE
                                              : MAP_ENTRY_SMALL));
   assign dataStart = header_reg.mapPresent ?
                      {1'b0, mapStart_reg} :
                      11'(IMAGE_START + IMAGE_BYTES * int'(indexSync1));
   assign dataOffset = byteAddr_reg - dataStart;
   // With a map, bytes up to the end of our entry are never image data:
   // the start address is not known until the entry has gone by
   assign inImage    = (byteAddr_reg >= 11'(IMAGE_START)) &&
                       (byteAddr_reg >= dataStart) &&
                       (!header_reg.mapPresent ||
                        byteAddr_reg > entryBase + (header_reg.largeMemory ?
                                       11'h002 : 11'h001)) &&
                       (dataOffset < 11'(IMAGE_BYTES));
   assign lastByte   = byteStrobe_reg && inImage &&
                       (dataOffset == 11'(IMAGE_BYTES - 1));
   // A checksum byte exists only with a map; ignore it when disabled
   assign checksumUsed = header_reg.checksumEnable &&
                         header_reg.mapPresent;
   assign commitPulse  = (state_reg == LOAD_S) && imageFull_reg &&
                         checkPass_reg;

   // Load sequence; failure is terminal until reset
   always_ff @(posedge clock) begin
      if (reset) begin
         state_reg     <= IDLE_S;
         header_reg    <= '0;
         burst_reg     <= 8'h00;
         crcByte_reg   <= 8'h00;
         xorSum_reg    <= 8'h00;
         mapStart_reg  <= 10'h000;
         image_reg     <= '0;
         imageFull_reg <= 1'b0;
         checkPass_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            IDLE_S: begin
               xorSum_reg    <= 8'h00;
               imageFull_reg <= 1'b0;
               if (modeSync[1] && !readEnableSync[1]) begin
                  state_reg <= LOAD_S;
               end
            end
            LOAD_S: begin
               if (imageFull_reg) begin
                  state_reg <= checkPass_reg ? DONE_S : FAIL_S;
               end else if (frameEnd) begin
                  state_reg <= FAIL_S;
               end else if (byteStrobe_reg) begin
                  if (byteAddr_reg >= 11'(MEMORY_BYTES)) begin
                     state_reg <= FAIL_S;
                  end
                  if (byteAddr_reg == 11'(HEADER_FLAGS_ADDR)) begin
                     header_reg <= header_t'(byteData_reg);
                     if (byteData_reg[3:0] < indexSync1) begin
                        state_reg <= FAIL_S;
                     end
                  end
                  if (byteAddr_reg == 11'(HEADER_BURST_ADDR)) begin
                     burst_reg <= byteData_reg;
                  end
                  if (header_reg.mapPresent &&
                      byteAddr_reg >= 11'(IMAGE_START)) begin
                     if (byteAddr_reg == entryBase) begin
                        crcByte_reg <= byteData_reg;
                     end
                     if (header_reg.largeMemory) begin
                        if (byteAddr_reg == entryBase + 11'h001) begin
                           mapStart_reg[9:8] <= byteData_reg[1:0];
                        end
                        if (byteAddr_reg == entryBase + 11'h002) begin
                           mapStart_reg[7:0] <= byteData_reg;
                        end
                     end else if (byteAddr_reg == entryBase + 11'h001) begin
                        mapStart_reg <= {2'h0, byteData_reg};
                     end
                  end
                  if (inImage) begin
                     image_reg[dataOffset[5:0]] <= byteData_reg;
                     xorSum_reg <= xorSum_reg ^ byteData_reg;
                  end
                  if (lastByte) begin
                     imageFull_reg <= 1'b1;
                     checkPass_reg <= !checksumUsed ||
                        ((xorSum_reg ^ byteData_reg) == crcByte_reg);
                  end
               end
            end
            DONE_S: begin
               state_reg <= DONE_S;
            end
            FAIL_S: begin
               state_reg <= FAIL_S;
            end
         endcase
      end
   end

   // Live registers change only at commit, so channels never see a
   // half-written image
   always_ff @(posedge clock) begin
      if (reset) begin
         ctrlRegs_reg <= scatterImage(DEFAULT_IMAGE, '0);
      end else if (commitPulse) begin
         ctrlRegs_reg <= scatterImage(image_reg, ctrlRegs_reg);
      end
   end

   // Status and field outputs, all from flip-flops
   assign loadRequest = (state_reg == LOAD_S);
   assign loadDone    = (state_reg == DONE_S);
   assign allDone     = loadDone;
   assign loadFailed  = (state_reg == FAIL_S);
   assign burstLength = burst_reg;
   assign ctrlRegs    = ctrlRegs_reg;
   assign powerDownPinOverride =
      ctrlRegs_reg[REG_OVERRIDES][POWER_DOWN_OVR_BIT];
   assign detectThresholdPinOverride =
      ctrlRegs_reg[REG_PIN_OVERRIDES][THRESHOLD_OVR_BIT];
   assign receiverDetectPinOverride =
      ctrlRegs_reg[REG_PIN_OVERRIDES][RXDET_OVR_BIT];

   AST_HEADER: assert property (@(posedge clock) disable iff (reset)
      (state_reg == LOAD_S && byteStrobe_reg && !imageFull_reg && !frameEnd &&
       byteAddr_reg == 11'h000) |=> header_reg == $past(byteData_reg))
      else $error("header flags not captured");
   AST_BURST: assert property (@(posedge clock) disable iff (reset)
      (state_reg == LOAD_S && byteStrobe_reg && !imageFull_reg && !frameEnd &&
       byteAddr_reg == 11'h002) |=> burstLength == $past(byteData_reg))
      else $error("burst length not captured");
   AST_NOMAP_START: assert property (@(posedge clock) disable iff (reset)
      !header_reg.mapPresent |->
      dataStart == 11'(3 + 37 * int'(indexSync1)))
      else $error("image start offset wrong");
   AST_POWER_DOWN: assert property (@(posedge clock) disable iff (reset)
      commitPulse |=> ctrlRegs[1] == $past(image_reg[0]))
      else $error("power-down register not loaded");
   AST_PWDN_OVR: assert property (@(posedge clock) disable iff (reset)
      commitPulse |=> powerDownPinOverride == $past(image_reg[1][3]))
      else $error("power-down override not loaded");
   AST_SWING: assert property (@(posedge clock) disable iff (reset)
      commitPulse |=> ctrlRegs[8'h10] == $past(image_reg[6]))
      else $error("swing register not loaded");
   AST_COPY: assert property (@(posedge clock) disable iff (reset)
      commitPulse |=> ctrlRegs[8'h5A] == $past(image_reg[35]) &&
                      ctrlRegs[8'h5B] == $past(image_reg[36]))
      else $error("copied registers wrong");
   AST_CHECKSUM: assert property (@(posedge clock) disable iff (reset)
      (lastByte && state_reg == LOAD_S && !frameEnd && !imageFull_reg &&
       !checksumUsed) |=> ##1 state_reg == DONE_S)
      else $error("unchecked image not accepted");
   AST_DONE: assert property (@(posedge clock) disable iff (reset)
      commitPulse |=> (loadDone && !loadRequest)[*3])
      else $error("bus not released after load");
   AST_HOLD: assert property (@(posedge clock) disable iff (reset)
      !commitPulse |=> $stable(ctrlRegs))
      else $error("registers changed without commit");
   AST_DEFAULTS: assert property (@(posedge clock) disable iff (reset)
      state_reg != DONE_S |-> ctrlRegs[8'h0F] == CH0_EQ_DEFAULT &&
      ctrlRegs[8'h10] == CH0_SWING_DEFAULT)
      else $error("defaults lost before load");

endmodule

// [test/eeprom_config_image_unpacker_tb.sv]
// Self-checking bench for the configuration image unpacker.
// Assumes the stream model stands in for the external serial memory.
`timescale 1ns/1ps
module eeprom_config_image_unpacker_tb;
   import eeprom_config_image_pkg::*;
   logic          clock = 1'b0;
   logic          reset = 1'b1;
   logic          busModeSelectPin = 1'b0;
   logic          readEnableLow = 1'b1;
   logic [3:0]    deviceIndex = 4'h0;
   logic          start = 1'b0;
   logic [7:0]    nBytes = 8'h00;
   logic          linkClock, linkData, linkFrame;
   logic          loadRequest, loadDone, allDone, loadFailed;
   logic [7:0]    burstLength;
   regs_t         ctrlRegs;
   logic          powerDownPinOverride, detectThresholdPinOverride;
   logic          receiverDetectPinOverride;
   logic [79:0]   notes[$];
   logic [7:0]    mem[0:127];
   logic [7:0]    img[0:36];
   logic [7:0]    dflt[0:36];
   logic [1023:0] memBits;
   logic          prevEnd = 1'b0;
   integer        seed = 32'h6ED4CDDF;
   integer        nMismatch = 0;
   integer        testsRun = 0;

   always #5 clock = ~clock;

   eeprom_config_image_unpacker i_dut (.clock(clock), .reset(reset),
      .busModeSelectPin(busModeSelectPin), .readEnableLow(readEnableLow),
      .deviceIndex(deviceIndex), .linkClock(linkClock),
      .linkData(linkData), .linkFrame(linkFrame),
      .loadRequest(loadRequest), .loadDone(loadDone), .allDone(allDone),
      .loadFailed(loadFailed), .burstLength(burstLength),
      .ctrlRegs(ctrlRegs), .powerDownPinOverride(powerDownPinOverride),
      .detectThresholdPinOverride(detectThresholdPinOverride),
      .receiverDetectPinOverride(receiverDetectPinOverride));
   eeprom_stream_model i_mem (.start(start), .nBytes(nBytes),
      .memBits(memBits), .linkClock(linkClock), .linkData(linkData),
      .linkFrame(linkFrame));

   // Expected outputs from image bytes; b[0] is image byte three
   function automatic logic [79:0] expSnap(input logic [7:0] b[0:36],
         input logic d, input logic f, input logic r, input logic [7:0] bl);
      return {b[1][3], b[2][1], b[3][6], d, f, d, r, 1'b0, bl, b[0],
         {2'b00, b[1][7:4], 1'b0, b[1][3]}, {b[1][2:0], b[2][7:3]},
         {1'b0, b[2][1:0], b[3][7:3]}, b[5], b[6], b[35], b[36]};
   endfunction

   function automatic logic [79:0] gotSnap();
      return {powerDownPinOverride, detectThresholdPinOverride,
         receiverDetectPinOverride, loadDone, loadFailed, allDone,
         loadRequest, 1'b0, burstLength, ctrlRegs[1], ctrlRegs[2],
         ctrlRegs[4], ctrlRegs[8], ctrlRegs[15], ctrlRegs[16],
         ctrlRegs[90], ctrlRegs[91]};
   endfunction

   task automatic chk(input logic [79:0] got, input logic [79:0] want);
      testsRun++;
      if (got !== want) begin
         nMismatch++;
         $display("BAD %0t got %h want %h", $time, got, want);
      end
   endtask

   task automatic finish_test();
      $display("Checks %0d mismatches %0d", testsRun, nMismatch);
      if (nMismatch == 0 && testsRun > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Each completion or failure retires the oldest note
   always @(negedge clock) begin
      if ((loadDone === 1'b1 || loadFailed === 1'b1) && !prevEnd) begin
         chk(gotSnap(), notes.pop_front());
      end
      prevEnd <= (loadDone === 1'b1) || (loadFailed === 1'b1);
   end

   // Case 0: plain header, second device; 1: map with checksum;
   // 2: cut short; 3: large map with a wrong checksum that must be ignored
   task automatic runCase(input int k);
      int         base;
      logic [7:0] crc;
      for (int i = 0; i < 128; i++) mem[i] = 8'($random(seed));
      mem[0] = (k == 0) ? 8'h01 : (k == 1) ? 8'hC0 :
               (k == 3) ? 8'h60 : 8'h00;
      mem[1] = 8'h00;
      base = (k == 0) ? 40 : (k == 1) ? 5 : (k == 3) ? 6 : 3;
      nBytes = (k == 2) ? 8'd23 : 8'(base + 37);
      crc = 8'h00;
      for (int i = 0; i < 37; i++) begin
         img[i] = mem[base+i];
         crc ^= img[i];
      end
      if (k == 1) begin
         mem[3] = crc;
         mem[4] = 8'h05;
      end
      // Only the low two bits of the high start byte count
      if (k == 3) begin
         mem[3] = ~crc;
         mem[4] = 8'hFC;
         mem[5] = 8'h06;
      end
      for (int i = 0; i < 128; i++) memBits[i*8+:8] = mem[i];
      // Long reset also flushes the pin synchronisers
      reset = 1'b1;
      busModeSelectPin = 1'b0;
      readEnableLow = 1'b1;
      deviceIndex = (k == 0) ? 4'h1 : 4'h0;
      repeat (10) @(negedge clock);
      reset = 1'b0;
      @(negedge clock);
      chk(gotSnap(), expSnap(dflt, 1'b0, 1'b0, 1'b0, 8'h00));
      busModeSelectPin = 1'b1;
      readEnableLow = 1'b0;
      for (int t = 0; t < 50 && loadRequest !== 1'b1; t++) @(negedge clock);
      notes.push_back((k == 2) ? expSnap(dflt, 1'b0, 1'b1, 1'b0, mem[2])
                               : expSnap(img, 1'b1, 1'b0, 1'b0, mem[2]));
      start = 1'b1;
      @(negedge clock);
      start = 1'b0;
      repeat (1500) @(negedge clock);
      chk(gotSnap(), expSnap(dflt, 1'b0, 1'b0, 1'b1, mem[2]));
      for (int t = 0; t < 20000 && !(loadDone === 1'b1 ||
           loadFailed === 1'b1); t++) @(negedge clock);
      repeat (30) @(negedge clock);
      chk({79'h0, notes.size() != 0}, 80'h0);
   endtask

   initial begin
      for (int i = 0; i < 37; i++) dflt[i] = 8'h00;
      dflt[2] = 8'h04;
      dflt[3] = 8'h07;
      dflt[5] = 8'h2F;
      dflt[6] = 8'hAD;
      dflt[35] = 8'h54;
      dflt[36] = 8'h54;
      for (int k = 0; k < 4; k++) runCase(k);
      finish_test();
   end

   // Four loads take well under 250 us; double it before giving up
   initial begin
      #500000;
      nMismatch++;
      finish_test();
   end
endmodule

// [test/eeprom_stream_model.sv]
// Behavioural serial memory that streams its bytes to the unpacker.
// Assumes the bench fills memBits and pulses start while the link idles.
`timescale 1ns/1ps
module eeprom_stream_model (
   input  wire logic          start,
   input  wire logic [7:0]    nBytes,
   input  wire logic [1023:0] memBits,
   output logic               linkClock,
   output logic               linkData,
   output logic               linkFrame
);
   // Link clock stands still between frames
   initial begin
      linkClock = 1'b0;
      linkData = 1'b1;
      linkFrame = 1'b0;
   end

   // Bytes go out from address zero, MSB first, 125 ns bit period
   always @(posedge start) begin
      linkFrame = 1'b1;
      #100;
      for (int i = 0; i < nBytes; i++) begin
         for (int b = 7; b >= 0; b--) begin
            linkData = memBits[i*8+b];
            #62.5 linkClock = 1'b1;
            #62.5 linkClock = 1'b0;
         end
      end
      #100 linkFrame = 1'b0;
      // Released line shows the inverse so a stale bit cannot pass
      linkData = ~linkData;
   end
endmodule
